// *** hw/nop_stage.sv ***
// residual overvoltage pick-up stage with avalon register slave
//
// What this block does
// - calculated residual is third of phase sum
// - takes five magnitudes every 5 ms update
// - source setting: none, calculated, third, fourth
// - third/fourth input only in residual mode
// - force status applies only with forcing enable
// - pick-up when magnitude exceeds threshold
// - release below 97 percent of threshold
// - threshold 1.00 to 99.00 percent, default 20
// - residual scaled so full fault is 100 percent
// - no source: calculated, else third, else fourth, else report none available
// - ratio indication 0.00 to 1250.00
// - remaining time to trip in 5 ms ticks
// - expected time tracks voltage in inverse mode
// - source and force settings ignore setting group
// - threshold per group, switch applies immediately
// - primary pick-up voltage in 0.1 V steps
// - blocking at pick-up gives blocked, not start
// - fixed delay trips after delay, zero at start
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module nop_stage
   import nop_pkg::*;
#(
   parameter int MAG_W = 16,
   parameter int DIV_W = 40
)(
   // clock and reset
   input  wire logic             CLOCK,
   input  wire logic             SRST,
   // avalon-mm slave
   input  wire logic [6:0]       AVS_ADDRESS,
   input  wire logic             AVS_READ,
   input  wire logic             AVS_WRITE,
   input  wire logic [31:0]      AVS_WRITEDATA,
   input  wire logic [3:0]       AVS_BYTEENABLE,
   output logic [31:0]           AVS_READDATA,
   output logic                  AVS_WAITREQUEST,
   // measurement front end
   input  wire logic             MEAS_VALID,
   input  wire logic [MAG_W-1:0] RES3_MAG,
   input  wire logic [MAG_W-1:0] RES4_MAG,
   input  wire logic [MAG_W-1:0] PH1_MAG,
   input  wire logic [MAG_W-1:0] PH2_MAG,
   input  wire logic [MAG_W-1:0] PH3_MAG,
   input  wire logic             BLOCK_IN,
   // stage outputs
   output logic                  START,
   output logic                  TRIP,
   output logic                  BLOCKED,
   output logic                  NO_RESIDUAL,
   output logic                  IRQ
);
   localparam logic [18:0] MAX_T = 19'(NOP_MAX_TICKS);

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [13:0] clamp_th(input logic [31:0] v);
      if (v < 32'(NOP_TH_MIN)) begin
         return NOP_TH_MIN;
      end else if (v > 32'(NOP_TH_MAX)) begin
         return NOP_TH_MAX;
      end
      return v[13:0];
   endfunction

   // settings and bus state
   logic [5:0]  ctrl_q, ctrl_d;
   logic [2:0]  cfg_q, cfg_d;
   logic [13:0] th0_q, th0_d, th1_q, th1_d;
   logic        grp_q, grp_d;
   logic [18:0] dt_q, dt_d;
   logic [12:0] k_q, k_d;
   logic [19:0] unp_q, unp_d, unr_q, unr_d;
   logic [3:0]  mask_q, mask_d, stat_q, stat_d, ev;
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d, rb;
   // measurement and stage state
   logic [MAG_W-1:0] r3_q, r3_d, r4_q, r4_d, p1_q, p1_d, p2_q, p2_d, p3_q, p3_d;
   logic             eval_q, eval_d;
   logic             pick_q, pick_d, start_q, start_d, trip_q, trip_d, blk_q, blk_d;
   logic [18:0]      cnt_q, cnt_d;
   logic             so_q, so_d, to_q, to_d, bo_q, bo_d, nores_q, nores_d, irq_q, irq_d;
   logic [19:0]      rem_q, rem_d;
   // indications
   nop_dseq_t        ds_q, ds_d;
   logic             go_q, go_d;
   logic [16:0]      ratio_q, ratio_d;
   logic [18:0]      inverse_time_mode_q, inverse_time_mode_d;
   logic [23:0]      prim_q, prim_d;
   // combinational helpers
   nop_src_t         sel, now;
   nop_force_t       frc;
   logic [13:0]      th;
   logic [MAG_W+1:0] sum;
   logic [MAG_W-1:0] calc, meas;
   logic [18:0]      op_t;
   logic             pk_n, acc, dv_done;
   logic [DIV_W-1:0] dv_num, dv_den, dv_q;

   assign sel = nop_src_t'(ctrl_q[NOP_CTRL_SRC_LSB +: 2]);
   assign frc = nop_force_t'(ctrl_q[NOP_CTRL_FRC_LSB +: 2]);
   assign th  = grp_q ? th1_q : th0_q;
   assign sum = (MAG_W+2)'(p1_q) + (MAG_W+2)'(p2_q) + (MAG_W+2)'(p3_q);
   // phases arrive in 0.01 % of phase-to-neutral nominal, so the third of
   // their sum already reads in 0.01 % of phase-to-neutral nominal
   assign calc = MAG_W'(sum / 3);

   // active channel
   always_comb begin
      now = SRC_NONE;
      unique case (sel)
         SRC_NONE: begin
            if (cfg_q[NOP_CFG_LN_BIT]) begin
               now = SRC_CALC;
            end else if (cfg_q[NOP_CFG_CH3_BIT]) begin
               now = SRC_U3;
            end else if (cfg_q[NOP_CFG_CH4_BIT]) begin
               now = SRC_U4;
            end
         end
         SRC_CALC: now = cfg_q[NOP_CFG_LN_BIT] ? SRC_CALC : SRC_NONE;
         SRC_U3:   now = cfg_q[NOP_CFG_CH3_BIT] ? SRC_U3 : SRC_NONE;
         SRC_U4:   now = cfg_q[NOP_CFG_CH4_BIT] ? SRC_U4 : SRC_NONE;
      endcase
      unique case (now)
         SRC_CALC: meas = calc;
         SRC_U3:   meas = r3_q;
         SRC_U4:   meas = r4_q;
         default:  meas = '0;
      endcase
   end

   // inverse mode uses the last computed figure, one update old at most
   assign op_t = ctrl_q[NOP_CTRL_INVERSE_TIME_MODE_BIT] ? inverse_time_mode_q : dt_q;
   assign acc  = (AVS_READ | AVS_WRITE) & ~wait_q;

   // readback mux
   always_comb begin
      rb = '0;
      unique case (AVS_ADDRESS & 7'h7c)
         NOP_CTRL_OFS:  rb = 32'(ctrl_q);
         NOP_CFG_OFS:   rb = 32'(cfg_q);
         NOP_TH0_OFS:   rb = 32'(th0_q);
         NOP_TH1_OFS:   rb = 32'(th1_q);
         NOP_GRP_OFS:   rb = 32'(grp_q);
         NOP_DT_OFS:    rb = 32'(dt_q);
         NOP_K_OFS:     rb = 32'(k_q);
         NOP_UNP_OFS:   rb = 32'(unp_q);
         NOP_UNR_OFS:   rb = 32'(unr_q);
         NOP_ISTAT_OFS: rb = 32'(stat_q);
         NOP_IMASK_OFS: rb = 32'(mask_q);
         NOP_NOW_OFS:   rb = 32'(now);
         NOP_RATIO_OFS: rb = 32'(ratio_q);
         NOP_EXP_OFS:   rb = 32'(op_t);
         NOP_REM_OFS:   rb = {{12{rem_q[19]}}, rem_q};
         NOP_PRIM_OFS:  rb = 32'(prim_q);
         NOP_STATE_OFS: rb = {28'h0, pick_q, bo_q, to_q, so_q};
         default:       rb = '0;
      endcase
   end

   // bus and settings: answer one cycle after the request
   always_comb begin
      logic [31:0] wd;
      wd      = be_merge(rb, AVS_WRITEDATA, AVS_BYTEENABLE);
      wait_d  = ~((AVS_READ | AVS_WRITE) & wait_q);
      rdata_d = (AVS_READ & wait_q) ? rb : rdata_q;
      ctrl_d  = ctrl_q;
      cfg_d   = cfg_q;
      th0_d   = th0_q;
      th1_d   = th1_q;
      grp_d   = grp_q;
      dt_d    = dt_q;
      k_d     = k_q;
      unp_d   = unp_q;
      unr_d   = unr_q;
      mask_d  = mask_q;
      stat_d  = stat_q;
      if (acc & AVS_WRITE) begin
         unique case (AVS_ADDRESS & 7'h7c)
            NOP_CTRL_OFS:  ctrl_d = wd[5:0];
            NOP_CFG_OFS:   cfg_d  = wd[2:0];
            NOP_TH0_OFS:   th0_d  = clamp_th(wd);
            NOP_TH1_OFS:   th1_d  = clamp_th(wd);
            NOP_GRP_OFS:   grp_d  = wd[0];
            NOP_DT_OFS:    dt_d   = (wd[18:0] > MAX_T) ? MAX_T : wd[18:0];
            NOP_K_OFS:     k_d    = wd[12:0];
            NOP_UNP_OFS:   unp_d  = wd[19:0];
            NOP_UNR_OFS:   unr_d  = wd[19:0];
            NOP_ISTAT_OFS: stat_d = stat_q & ~wd[3:0];
            NOP_IMASK_OFS: mask_d = wd[3:0];
            default:       ;
         endcase
      end
      // a new event wins over a clear in the same cycle
      stat_d = stat_d | ev;
      irq_d  = |(stat_d & mask_d);
   end

   // stage evaluation, once per measurement update
   always_comb begin
      r3_d    = MEAS_VALID ? RES3_MAG : r3_q;
      r4_d    = MEAS_VALID ? RES4_MAG : r4_q;
      p1_d    = MEAS_VALID ? PH1_MAG : p1_q;
      p2_d    = MEAS_VALID ? PH2_MAG : p2_q;
      p3_d    = MEAS_VALID ? PH3_MAG : p3_q;
      eval_d  = MEAS_VALID;
      pk_n    = pick_q;
      pick_d  = pick_q;
      start_d = start_q;
      trip_d  = trip_q;
      blk_d   = blk_q;
      cnt_d   = cnt_q;
      rem_d   = rem_q;
      nores_d = (now == SRC_NONE);
      if (eval_q) begin
         if (now == SRC_NONE) begin
            pk_n = 1'b0;
         end else if (!pick_q && 32'(meas) > 32'(th)) begin
            pk_n = 1'b1;
         end else if (pick_q && 32'(meas) * 100 < 32'(th) * NOP_HYST_PCT) begin
            pk_n = 1'b0;
         end
         pick_d = pk_n;
         if (!pk_n) begin
            start_d = 1'b0;
            trip_d  = 1'b0;
            blk_d   = 1'b0;
            cnt_d   = '0;
         end else if (!pick_q) begin
            blk_d   = BLOCK_IN;
            start_d = ~BLOCK_IN;
            trip_d  = ~BLOCK_IN & (op_t == '0);
            cnt_d   = '0;
         end else if (start_q && BLOCK_IN) begin
            start_d = 1'b0;
            trip_d  = 1'b0;
            cnt_d   = '0;
         end else if (start_q) begin
            if (cnt_q < MAX_T) begin
               cnt_d = cnt_q + 19'd1;
            end
            trip_d = trip_q | (cnt_d >= op_t);
         end
         rem_d = start_d ? 20'(op_t) - 20'(cnt_d) : '0;
      end
      so_d = start_d;
      to_d = trip_d;
      bo_d = blk_d;
      if (ctrl_q[NOP_CTRL_FEN_BIT]) begin
         unique case (frc)
            FRC_NORMAL:  ;
            FRC_START: begin
               so_d = 1'b1;
               to_d = 1'b0;
               bo_d = 1'b0;
            end
            FRC_TRIP: begin
               so_d = 1'b1;
               to_d = 1'b1;
               bo_d = 1'b0;
            end
            FRC_BLOCKED: begin
               so_d = 1'b0;
               to_d = 1'b0;
               bo_d = 1'b1;
            end
         endcase
      end
      ev = '0;
      ev[NOP_IRQ_START] = so_d & ~so_q;
      ev[NOP_IRQ_TRIP]  = to_d & ~to_q;
      ev[NOP_IRQ_BLOCK] = bo_d & ~bo_q;
      ev[NOP_IRQ_NORES] = nores_d & ~nores_q;
   end

   // indication arithmetic, one division after another on each update
   always_comb begin
      ds_d    = ds_q;
      go_d    = 1'b0;
      ratio_d = ratio_q;
      inverse_time_mode_d  = inverse_time_mode_q;
      prim_d  = prim_q;
      dv_num  = '0;
      dv_den  = '0;
      unique case (ds_q)
         DS_IDLE: begin
            if (eval_q) begin
               ds_d = DS_RATIO;
               go_d = 1'b1;
            end
         end
         DS_RATIO: begin
            dv_num = DIV_W'(meas) * DIV_W'(100);
            dv_den = DIV_W'(th);
            if (dv_done) begin
               ratio_d = (dv_q > DIV_W'(NOP_RATIO_MAX)) ? 17'(NOP_RATIO_MAX) : dv_q[16:0];
               ds_d    = DS_TIME;
               go_d    = 1'b1;
            end
         end
         DS_TIME: begin
            // at or under threshold the divisor is zero and saturates
            dv_num = DIV_W'(k_q) * DIV_W'(th) * DIV_W'(NOP_K_TICKS);
            dv_den = (meas > 16'(th)) ? DIV_W'(meas) - DIV_W'(th) : '0;
            if (dv_done) begin
               inverse_time_mode_d = (dv_q > DIV_W'(MAX_T)) ? MAX_T : dv_q[18:0];
               ds_d   = DS_PRIM;
               go_d   = 1'b1;
            end
         end
         DS_PRIM: begin
            dv_num = DIV_W'(th) * DIV_W'((now == SRC_CALC) ? unp_q : unr_q);
            dv_den = DIV_W'(NOP_PRIM_DIV);
            if (dv_done) begin
               prim_d = (now == SRC_NONE) ? '0 : dv_q[23:0];
               ds_d   = DS_IDLE;
            end
         end
      endcase
   end

   nop_div #(
      .W    (DIV_W)
   ) u_div (
      .clk  (CLOCK),
      .rst  (SRST),
      .go   (go_q),
      .num  (dv_num),
      .den  (dv_den),
      .done (dv_done),
      .quot (dv_q)
   );

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ctrl_q  <= NOP_CTRL_RST;
         cfg_q   <= NOP_CFG_RST;
         th0_q   <= NOP_TH_RST;
         th1_q   <= NOP_TH_RST;
         grp_q   <= 1'b0;
         dt_q    <= 19'(NOP_DT_RST);
         k_q     <= NOP_K_RST;
         unp_q   <= NOP_UN_RST;
         unr_q   <= NOP_UN_RST;
         mask_q  <= '0;
         stat_q  <= '0;
         wait_q  <= 1'b1;
         rdata_q <= '0;
         irq_q   <= 1'b0;
         r3_q    <= '0;
         r4_q    <= '0;
         p1_q    <= '0;
         p2_q    <= '0;
         p3_q    <= '0;
         eval_q  <= 1'b0;
         pick_q  <= 1'b0;
         start_q <= 1'b0;
         trip_q  <= 1'b0;
         blk_q   <= 1'b0;
         cnt_q   <= '0;
         rem_q   <= '0;
         so_q    <= 1'b0;
         to_q    <= 1'b0;
         bo_q    <= 1'b0;
         nores_q <= 1'b0;
         ds_q    <= DS_IDLE;
         go_q    <= 1'b0;
         ratio_q <= '0;
         inverse_time_mode_q  <= MAX_T;
         prim_q  <= '0;
      end else begin
         ctrl_q  <= ctrl_d;
         cfg_q   <= cfg_d;
         th0_q   <= th0_d;
         th1_q   <= th1_d;
         grp_q   <= grp_d;
         dt_q    <= dt_d;
         k_q     <= k_d;
         unp_q   <= unp_d;
         unr_q   <= unr_d;
         mask_q  <= mask_d;
         stat_q  <= stat_d;
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         irq_q   <= irq_d;
         r3_q    <= r3_d;
         r4_q    <= r4_d;
         p1_q    <= p1_d;
         p2_q    <= p2_d;
         p3_q    <= p3_d;
         eval_q  <= eval_d;
         pick_q  <= pick_d;
         start_q <= start_d;
         trip_q  <= trip_d;
         blk_q   <= blk_d;
         cnt_q   <= cnt_d;
         rem_q   <= rem_d;
         so_q    <= so_d;
         to_q    <= to_d;
         bo_q    <= bo_d;
         nores_q <= nores_d;
         ds_q    <= ds_d;
         go_q    <= go_d;
         ratio_q <= ratio_d;
         inverse_time_mode_q  <= inverse_time_mode_d;
         prim_q  <= prim_d;
      end
   end

   assign AVS_READDATA    = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign START           = so_q;
   assign TRIP            = to_q;
   assign BLOCKED         = bo_q;
   assign NO_RESIDUAL     = nores_q;
   assign IRQ             = irq_q;
endmodule
`default_nettype wire

// *** hw/nop_pkg.sv ***
// shared constants and types of the residual overvoltage pick-up stage
package nop_pkg;

   // register byte offsets
   localparam logic [6:0] NOP_CTRL_OFS   = 7'h00;
   localparam logic [6:0] NOP_CFG_OFS    = 7'h04;
   localparam logic [6:0] NOP_TH0_OFS    = 7'h08;
   localparam logic [6:0] NOP_TH1_OFS    = 7'h0c;
   localparam logic [6:0] NOP_GRP_OFS    = 7'h10;
   localparam logic [6:0] NOP_DT_OFS     = 7'h14;
   localparam logic [6:0] NOP_K_OFS      = 7'h18;
   localparam logic [6:0] NOP_UNP_OFS    = 7'h1c;
   localparam logic [6:0] NOP_UNR_OFS    = 7'h20;
   localparam logic [6:0] NOP_ISTAT_OFS  = 7'h24;
   localparam logic [6:0] NOP_IMASK_OFS  = 7'h28;
   localparam logic [6:0] NOP_NOW_OFS    = 7'h2c;
   localparam logic [6:0] NOP_RATIO_OFS  = 7'h30;
   localparam logic [6:0] NOP_EXP_OFS    = 7'h34;
   localparam logic [6:0] NOP_REM_OFS    = 7'h38;
   localparam logic [6:0] NOP_PRIM_OFS   = 7'h3c;
   localparam logic [6:0] NOP_STATE_OFS  = 7'h40;

   // control and config register fields
   localparam int NOP_CTRL_SRC_LSB   = 0;
   localparam int NOP_CTRL_FRC_LSB   = 2;
   localparam int NOP_CTRL_FEN_BIT   = 4;
   localparam int NOP_CTRL_INVERSE_TIME_MODE_BIT  = 5;
   localparam int NOP_CFG_LN_BIT     = 0;
   localparam int NOP_CFG_CH3_BIT    = 1;
   localparam int NOP_CFG_CH4_BIT    = 2;

   // interrupt status bits
   localparam int NOP_IRQ_START = 0;
   localparam int NOP_IRQ_TRIP  = 1;
   localparam int NOP_IRQ_BLOCK = 2;
   localparam int NOP_IRQ_NORES = 3;

   // reset values and ranges, threshold in 0.01 % of nominal
   localparam logic [5:0]  NOP_CTRL_RST = 6'h00;
   localparam logic [2:0]  NOP_CFG_RST  = 3'h1;
   localparam logic [13:0] NOP_TH_RST   = 14'd2000;
   localparam logic [13:0] NOP_TH_MIN   = 14'd100;
   localparam logic [13:0] NOP_TH_MAX   = 14'd9900;
   localparam logic [12:0] NOP_K_RST    = 13'd5;
   localparam logic [19:0] NOP_UN_RST   = 20'd20000;
   localparam int          NOP_HYST_PCT = 97;
   localparam int          NOP_RATIO_MAX = 125000;
   localparam int          NOP_PRIM_DIV  = 1000;

   // timing: one tick is one measurement update
   localparam int NOP_TICK_US   = 5000;
   localparam int NOP_MAX_S     = 1800;
   localparam int NOP_DT_RST_MS = 40;
   localparam int NOP_MAX_TICKS = NOP_MAX_S * 1000000 / NOP_TICK_US;
   localparam int NOP_DT_RST    = NOP_DT_RST_MS * 1000 / NOP_TICK_US;
   localparam int NOP_K_TICKS   = 10000 / NOP_TICK_US;

   typedef enum logic [1:0] {SRC_NONE, SRC_CALC, SRC_U3, SRC_U4} nop_src_t;
   typedef enum logic [1:0] {FRC_NORMAL, FRC_START, FRC_TRIP, FRC_BLOCKED} nop_force_t;
   typedef enum logic [1:0] {DS_IDLE, DS_RATIO, DS_TIME, DS_PRIM} nop_dseq_t;

endpackage

// *** hw/nop_div.sv ***
// bit-serial restoring divider shared by the indication arithmetic
`timescale 1ns/1ns
`default_nettype none
module nop_div #(
   parameter int W = 40
)(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // request
   input  wire logic         go,
   input  wire logic [W-1:0] num,
   input  wire logic [W-1:0] den,
   // answer
   output logic              done,
   output logic [W-1:0]      quot
);
   localparam int CW = $clog2(W + 1);

   logic [W-1:0]  rem_q, rem_d, quo_q, quo_d, den_q, den_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic          busy_q, busy_d, done_q, done_d;
   logic [W:0]    sh;

   // zero divisor yields all ones, read as saturation by the caller
   always_comb begin
      sh     = {rem_q, quo_q[W-1]};
      rem_d  = rem_q;
      quo_d  = quo_q;
      den_d  = den_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (go) begin
         rem_d  = '0;
         quo_d  = num;
         den_d  = den;
         cnt_d  = CW'(W);
         busy_d = 1'b1;
      end else if (busy_q) begin
         if (sh >= {1'b0, den_q}) begin
            rem_d = W'(sh - {1'b0, den_q});
            quo_d = {quo_q[W-2:0], 1'b1};
         end else begin
            rem_d = sh[W-1:0];
            quo_d = {quo_q[W-2:0], 1'b0};
         end
         cnt_d = cnt_q - 1'b1;
         if (cnt_q == CW'(1)) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rem_q  <= '0;
         quo_q  <= '0;
         den_q  <= '0;
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         rem_q  <= rem_d;
         quo_q  <= quo_d;
         den_q  <= den_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;
   assign quot = quo_q;
endmodule
`default_nettype wire

// *** tb/nop_stage_props.sv ***
// concurrent checks on the stage ports
`timescale 1ns/1ns
`default_nettype none
module nop_stage_props (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // register bus
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   // stage
   input wire logic MEAS_VALID,
   input wire logic START,
   input wire logic TRIP,
   input wire logic BLOCKED,
   input wire logic IRQ
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);

   a_start_cause: assert property ($rose(START) |-> $past(MEAS_VALID, 2) || $past(AVS_WRITE, 1)
      || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)) else $error("start rose without update or write");
   // trip and blocked only move after an evaluation or a settings write
   a_trip_quiet: assert property (!$past(MEAS_VALID, 2) && !$past(AVS_WRITE, 1) && !$past(AVS_WRITE, 2)
      && !$past(AVS_WRITE, 3) |-> $stable(TRIP) && $stable(BLOCKED)) else $error("trip or blocked moved alone");
   a_trip_start: assert property (TRIP |-> START) else $error("trip without start");
   a_block_alone: assert property ($rose(BLOCKED) |-> !START) else $error("blocked together with start");
   a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus request not answered next cycle");
   a_wait_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("waitrequest low too long");
   a_reset_quiet: assert property ($fell(SRST) |-> !START && !TRIP && !BLOCKED && !IRQ && AVS_WAITREQUEST)
      else $error("outputs not quiet after reset");
   a_irq_cause: assert property ($rose(IRQ) |-> $past(MEAS_VALID, 2) || $past(AVS_WRITE, 1)
      || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)) else $error("irq rose without cause");
endmodule
`default_nettype wire

// *** tb/nop_front.sv ***
// measurement front end model: one update pulse per period
`timescale 1ns/1ns
`default_nettype none
module nop_front #(
   parameter int PERIOD = 200
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // values to present
   input  wire logic [15:0] res_set,
   input  wire logic [15:0] ph_set,
   // toward the stage
   output logic             meas_valid,
   output logic [15:0]      res_mag,
   output logic [15:0]      ph_mag
);
   int cnt_q;
   // period shortened from 5 ms; the stage counts updates, not time
   always_ff @(posedge clk) begin
      cnt_q <= (rst || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      meas_valid <= !rst && cnt_q == PERIOD - 1;
   end
   // between updates the lines carry garbage, never the held value
   assign res_mag = meas_valid ? res_set : ~res_set;
   assign ph_mag = meas_valid ? ph_set : ~ph_set;
endmodule
`default_nettype wire

// *** tb/nop_stage_tb.sv ***
// self-checking bench for the residual overvoltage stage
`timescale 1ns/1ns
`default_nettype none
module nop_stage_tb;
   import nop_pkg::*;
   logic        CLOCK = 0, SRST = 1, AVS_READ = 0, AVS_WRITE = 0, BLOCK_IN = 0;
   logic [6:0]  AVS_ADDRESS = '0;
   logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, th, hold;
   logic        AVS_WAITREQUEST, MEAS_VALID, START, TRIP, BLOCKED, NO_RESIDUAL, IRQ;
   logic [15:0] res_set = '0, ph_set = '0, res_mag, ph_mag, rnd = 16'h0053;
   logic [31:0] exp_q[$];
   logic [31:0] fexp[4] = '{32'h0, 32'h1, 32'h3, 32'h4};
   int          n_errors = 0, n_tests = 0, cyc = 0;

   initial forever #2 CLOCK = ~CLOCK;

   nop_front u_front (.clk(CLOCK), .rst(SRST), .res_set(res_set), .ph_set(ph_set),
      .meas_valid(MEAS_VALID), .res_mag(res_mag), .ph_mag(ph_mag));
   nop_stage uut (.CLOCK(CLOCK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MEAS_VALID(MEAS_VALID),
      .RES3_MAG(res_mag), .RES4_MAG(res_mag), .PH1_MAG(ph_mag), .PH2_MAG(ph_mag), .PH3_MAG(ph_mag),
      .BLOCK_IN(BLOCK_IN), .START(START), .TRIP(TRIP), .BLOCKED(BLOCKED), .NO_RESIDUAL(NO_RESIDUAL), .IRQ(IRQ));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one access; a read notes its expected word for the monitor
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      if (!wr)
         exp_q.push_back(d);
      // request stands until the edge that samples waitrequest low
      do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
      AVS_WRITE <= 0;
      AVS_READ <= 0;
   endtask

   // both updates carry the new value, so the stage evaluates it twice
   task automatic upd(input logic [31:0] r);
      res_set <= r[15:0];
      repeat (2) @(posedge CLOCK iff MEAS_VALID);
      repeat (4) @(posedge CLOCK);
   endtask

   // read data taken at the edge that accepts the read
   always @(posedge CLOCK) begin
      if (AVS_READ && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0)
         chk(AVS_READDATA, exp_q.pop_front());
   end

   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         end_of_test();
      end
   end

   initial begin
      repeat (2) @(posedge CLOCK);
      SRST <= 0;
      rnd = lfsr(rnd);
      th = 100 + rnd % 9800;
      hold = (th * 97 + 99) / 100;
      bus(0, NOP_CTRL_OFS, 0);
      bus(0, NOP_CFG_OFS, 1);
      bus(0, NOP_TH0_OFS, 2000);
      bus(0, NOP_NOW_OFS, 32'(SRC_CALC));
      bus(1, 7'h7c, 5);
      bus(0, 7'h7c, 0);
      bus(1, NOP_CFG_OFS, 0);
      bus(0, NOP_NOW_OFS, 0);
      upd(0);
      chk({31'h0, NO_RESIDUAL}, 1);
      bus(1, NOP_CFG_OFS, 7);
      for (int s = 1; s < 4; s++) begin
         bus(1, NOP_CTRL_OFS, s);
         bus(0, NOP_NOW_OFS, s);
      end
      $display("source selection done");
      bus(1, NOP_CTRL_OFS, 2);
      bus(1, NOP_DT_OFS, 0);
      bus(1, NOP_TH1_OFS, 50);
      bus(0, NOP_TH1_OFS, 100);
      bus(1, NOP_TH0_OFS, th);
      bus(1, NOP_IMASK_OFS, 1);
      upd(th);
      bus(0, NOP_STATE_OFS, 0);
      upd(th + 1);
      bus(0, NOP_STATE_OFS, 32'hb);
      chk({29'h0, BLOCKED, TRIP, START}, 3);
      chk({31'h0, IRQ}, 1);
      // no-residual event of the source test is still pending
      bus(0, NOP_ISTAT_OFS, 32'hb);
      upd(hold);
      bus(0, NOP_STATE_OFS, 32'hb);
      upd(hold - 1);
      bus(0, NOP_STATE_OFS, 0);
      bus(1, NOP_ISTAT_OFS, 32'hf);
      bus(0, NOP_ISTAT_OFS, 0);
      chk({31'h0, IRQ}, 0);
      $display("pick-up and release done");
      BLOCK_IN <= 1;
      upd(th + 1);
      bus(0, NOP_STATE_OFS, 32'hc);
      chk({29'h0, BLOCKED, TRIP, START}, 4);
      upd(0);
      BLOCK_IN <= 0;
      bus(1, NOP_CTRL_OFS, 32'h0a);
      upd(0);
      bus(0, NOP_STATE_OFS, 0);
      for (int f = 0; f < 4; f++) begin
         bus(1, NOP_CTRL_OFS, 32'h12 | (f << 2));
         upd(0);
         bus(0, NOP_STATE_OFS, fexp[f]);
      end
      $display("blocking and forcing done");
      bus(1, NOP_CTRL_OFS, 2);
      bus(1, NOP_TH1_OFS, 9900);
      bus(1, NOP_GRP_OFS, 1);
      bus(0, NOP_CTRL_OFS, 2);
      upd(th + 1);
      bus(0, NOP_STATE_OFS, 0);
      bus(1, NOP_GRP_OFS, 0);
      upd(th + 1);
      bus(0, NOP_STATE_OFS, 32'hb);
      $display("setting groups done");
      bus(0, NOP_RATIO_OFS, (th + 1) * 100 / th);
      bus(0, NOP_PRIM_OFS, th * NOP_UN_RST / NOP_PRIM_DIV);
      upd(0);
      bus(1, NOP_DT_OFS, 3);
      upd(th + 1);
      bus(0, NOP_STATE_OFS, 32'h9);
      bus(0, NOP_REM_OFS, 2);
      upd(th + 1);
      bus(0, NOP_STATE_OFS, 32'hb);
      bus(0, NOP_EXP_OFS, 3);
      bus(1, NOP_CTRL_OFS, 32'h22);
      bus(0, NOP_EXP_OFS, NOP_K_RST * NOP_K_TICKS * th);
      // phases at twice the threshold, residual channel at zero
      ph_set <= 16'(2 * th);
      bus(1, NOP_CTRL_OFS, 1);
      upd(0);
      bus(0, NOP_RATIO_OFS, 200);
      $display("indications and delay done");
      end_of_test();
   end
endmodule

bind nop_stage nop_stage_props u_props (.CLOCK(CLOCK), .SRST(SRST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .MEAS_VALID(MEAS_VALID), .START(START), .TRIP(TRIP),
   .BLOCKED(BLOCKED), .IRQ(IRQ));
`default_nettype wire
